//--- include/uart_cfg.svh
// shared constants for the serial port and its remote end
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define DIV_ZERO    16'h0000
`define DIV_ONE     16'h0001
`define ACC_ZERO    3'h0
`define CARRY_BIT   3
`define BITS_EIGHT  4'h8
`define BITS_NINE   4'h9
`define BITS_ONE    4'h1
`define BREAK_BITS  4'hd
`define STOPS_ONE   2'h1
`define STOPS_TWO   2'h2
`define PAR_EVEN    2'h0
`define PAR_ODD     2'h1
`define PAR_MARK    2'h2
`define PAR_SPACE   2'h3
`define IDLE_LEVEL  1'b1
`define START_LEVEL 1'b0
`define HOLD_ZERO   17'h0_0000
`define HOLD_ONE    17'h0_0001
`define WORD_ONE    9'h001
`define FRAME_FILL  12'h800
`endif

//--- include/uart_pkg.sv
// types and frame arithmetic shared by both ends of the serial link
`include "uart_cfg.svh"
package uart_pkg;

  // control settings held by the port
  typedef struct packed {
    logic        port_enable;
    logic        transmit_enable;
    logic        receive_enable;
    logic        nine_bit_select;
    logic        parity_enable;
    logic [1:0]  parity_type_field;
    logic        two_stop_select;
    logic        tx_ninth_bit;
    logic        break_request;
    logic        tx_interrupt_enable;
    logic        divider_range_select;
    logic [2:0]  baud_fraction_field;
    logic [15:0] baud_divider;
  } ctrl_type;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_BREAK, TX_STOP} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

  // fraction accumulator step, bit 3 is the carry
  function automatic logic [3:0] acc_step(input logic [2:0] acc, input logic [2:0] frac);
    return {1'b0, acc} + {1'b0, frac};
  endfunction

  // countdown load for one bit time, lengthened by the carry
  function automatic logic [15:0] bit_count(input logic [15:0] div, input logic carry);
    return div - `DIV_ONE + {15'h0000, carry};
  endfunction

  function automatic logic [3:0] payload_bits(input logic nine);
    return nine ? `BITS_NINE : `BITS_EIGHT;
  endfunction

  // payload with the top slot replaced by parity when enabled
  function automatic logic [8:0] frame_word(input logic [8:0] data, input logic nine,
                                            input logic paren, input logic [1:0] ptype);
    logic [3:0] top;
    logic [8:0] mask;
    logic [8:0] w;
    logic       p;
    top  = payload_bits(nine) - `BITS_ONE;
    mask = paren ? ((`WORD_ONE << top) - `WORD_ONE) : ((`WORD_ONE << payload_bits(nine)) - `WORD_ONE);
    w    = data & mask;
    unique case (ptype)
      `PAR_EVEN: p = ^w;
      `PAR_ODD:  p = ~^w;
      `PAR_MARK: p = 1'b1;
      default:   p = 1'b0;
    endcase
    if (paren) begin
      w[top] = p;
    end
    return w;
  endfunction

endpackage

//--- include/uart_link_if.sv
// serial line between the port and the remote transceiver
`include "uart_cfg.svh"
interface uart_link_if;
  logic serial_out;
  logic serial_out_oe;
  logic serial_in;
  logic line_tx;

  // a released output pin floats to the idle level
  assign line_tx = serial_out_oe ? serial_out : `IDLE_LEVEL;

  modport dev (output serial_out, output serial_out_oe, input serial_in);
  modport far (input line_tx, output serial_in);
endinterface

//--- core/uart_port.sv
// serial port: frame format, enable control, transmitter and receiver
// Notes on behaviour
// RULE1: start, 8/9 data LSB first, 1-2 stops
// RULE2: even/odd/mark/space/none parity, reset 8N1
// RULE3: one divider times both directions, same format
// RULE4: enabled pins carry serial data, idle high
// RULE5: port disable releases pins, empties buffer
// RULE6: disable clears enables and flags, sets idles
// RULE7: disable aborts at once, config kept
// RULE8: top payload bit can mark address
// RULE9: two stops transmit only, receiver checks one
// RULE10: parity or address takes top payload slot
// RULE11: ninth transmitted bit comes from control bit
// RULE12: shift reload only after stop bits
// RULE13: start needs enable, data and baud clock
// RULE14: transmit disable stops output, resets transmitter
// RULE15: empty flag gates writes, status then write (the empty flag clears on a buffered write with no status read)
// RULE16: interrupt enable gates empty flag to request
// RULE17: busy write buffered, idle write goes direct
// RULE18: idle flag set per frame, same clearing
// RULE19: held break request arms a break frame
// RULE20: break frames never raise the interrupt
// RULE21: breaks repeat while held, then stop bits
// RULE22: bit time is divider plus fraction carry
// RULE23: software keeps divider at range minimum
// RULE24: parity over data, mark one, space zero

`include "uart_cfg.svh"
module uart_rx_core (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  // settings and line
  input  wire logic               i_active,
  input  wire logic               i_line,
  input  wire uart_pkg::ctrl_type i_ctrl,
  // received character
  output logic                    o_done,
  output logic [8:0]              o_word,
  output logic                    o_frame_err,
  output logic                    o_par_err,
  output logic                    o_noise,
  output logic                    o_busy
);
  uart_pkg::rx_state_type state_q;
  logic [15:0] cnt_q;
  logic [2:0]  acc_q;
  logic [2:0]  hist_q;
  logic [3:0]  left_q;
  logic [8:0]  sh_q;
  logic        noise_q;

  // three-sample majority around the sample point
  wire       maj     = (hist_q[0] & hist_q[1]) | (hist_q[0] & hist_q[2]) | (hist_q[1] & hist_q[2]);
  wire       split   = ~&hist_q & |hist_q;
  wire       tick    = cnt_q == `DIV_ZERO;
  wire [3:0] step    = uart_pkg::acc_step(acc_q, i_ctrl.baud_fraction_field); // RULE22
  wire [15:0] reload = uart_pkg::bit_count(i_ctrl.baud_divider, step[`CARRY_BIT]); // RULE3
  wire [3:0] n_bits  = uart_pkg::payload_bits(i_ctrl.nine_bit_select);
  wire [8:0] word    = i_ctrl.nine_bit_select ? sh_q : {1'b0, sh_q[8:1]};
  wire [8:0] expect_w = uart_pkg::frame_word(word, i_ctrl.nine_bit_select, i_ctrl.parity_enable,
                                             i_ctrl.parity_type_field);
  wire       fall    = hist_q[1] & ~hist_q[0];

  assign o_busy = state_q != uart_pkg::RX_IDLE;

  // receive sequencer, one stop bit checked
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q     <= uart_pkg::RX_IDLE;
      cnt_q       <= `DIV_ZERO;
      acc_q       <= `ACC_ZERO;
      hist_q      <= '1;
      left_q      <= '0;
      sh_q        <= '0;
      noise_q     <= 1'b0;
      o_done      <= 1'b0;
      o_word      <= '0;
      o_frame_err <= 1'b0;
      o_par_err   <= 1'b0;
      o_noise     <= 1'b0;
    end else begin
      hist_q <= {hist_q[1:0], i_line};
      o_done <= 1'b0;
      if (!tick) begin
        cnt_q <= cnt_q - `DIV_ONE;
      end
      if (!i_active) begin
        state_q <= uart_pkg::RX_IDLE;
      end else begin
        unique case (state_q)
          uart_pkg::RX_IDLE: begin
            if (fall) begin
              state_q <= uart_pkg::RX_START;
              cnt_q   <= i_ctrl.baud_divider >> 1;
              acc_q   <= `ACC_ZERO;
            end
          end
          uart_pkg::RX_START: begin
            if (tick) begin
              state_q <= maj ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
              cnt_q   <= reload;
              acc_q   <= step[2:0];
              left_q  <= n_bits;
              noise_q <= split;
            end
          end
          uart_pkg::RX_DATA: begin
            if (tick) begin
              sh_q    <= {maj, sh_q[8:1]};
              noise_q <= noise_q | split;
              left_q  <= left_q - `BITS_ONE;
              cnt_q   <= reload;
              acc_q   <= step[2:0];
              if (left_q == `BITS_ONE) begin
                state_q <= uart_pkg::RX_STOP;
              end
            end
          end
          uart_pkg::RX_STOP: begin
            if (tick) begin
              state_q     <= uart_pkg::RX_IDLE;
              o_done      <= 1'b1;
              o_word      <= word;
              o_frame_err <= ~maj; // RULE9
              o_par_err   <= i_ctrl.parity_enable & (expect_w != word);
              o_noise     <= noise_q | split;
            end
          end
        endcase
      end
    end
  end
endmodule

module uart_port (
  // clock and reset
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RSTN,
  // control settings
  input  wire logic               I_CTRL_WE,
  input  wire uart_pkg::ctrl_type I_CTRL,
  // status and data access
  input  wire logic               I_STATUS_RD,
  input  wire logic               I_DATA_WE,
  input  wire logic [7:0]         I_DATA,
  input  wire logic               I_DATA_RD,
  // readback and status
  output uart_pkg::ctrl_type      O_CTRL,
  output logic                    O_TX_EMPTY,
  output logic                    O_TX_IDLE,
  output logic                    O_IRQ,
  output logic                    O_RX_AVAIL,
  output logic                    O_RX_IDLE,
  output logic                    O_OVERRUN,
  output logic                    O_FRAMING,
  output logic                    O_PARITY,
  output logic                    O_NOISE,
  output logic [2:0]              O_RX_COUNT,
  output logic [8:0]              O_RX_DATA,
  // serial line
  uart_link_if.dev                LINK
);
  uart_pkg::ctrl_type     ctrl_q, ctrl_d;
  uart_pkg::tx_state_type state_q, state_d;
  logic [15:0] cnt_q;
  logic [2:0]  acc_q;
  logic [3:0]  left_q, left_d;
  logic [1:0]  stops_q, stops_d;
  logic [8:0]  shift_q, shift_d;
  logic [7:0]  buf_q;
  logic [16:0] hold_q;
  logic        brk_q, brk_d, brk_arm_q, buf_full_q, seen_q, out_q, oe_q;
  logic        rx_done, rx_ferr, rx_perr, rx_noise, rx_busy;
  logic [8:0]  rx_word;

  // settings write; disable clears enables and break request
  always_comb begin
    ctrl_d = I_CTRL_WE ? I_CTRL : ctrl_q;
    if (!ctrl_d.port_enable) begin // RULE6
      ctrl_d.transmit_enable = 1'b0;
      ctrl_d.receive_enable  = 1'b0;
      ctrl_d.break_request   = 1'b0;
    end
  end

  // transmit qualifiers
  wire tx_on    = ctrl_q.port_enable & ctrl_q.transmit_enable;
  wire baud_ok  = ctrl_q.baud_divider != `DIV_ZERO;
  wire tick     = cnt_q == `DIV_ZERO;
  wire in_idle  = state_q == uart_pkg::TX_IDLE;
  wire stop_end = (state_q == uart_pkg::TX_STOP) & tick & (stops_q == `STOPS_ONE);
  wire wr_ok    = I_DATA_WE & O_TX_EMPTY & ctrl_q.port_enable; // RULE15
  wire can_load = tx_on & baud_ok & (in_idle | stop_end) & ~brk_arm_q; // RULE12 RULE13
  wire direct   = can_load & ~buf_full_q & wr_ok; // RULE17
  wire from_buf = can_load & buf_full_q;
  wire load     = direct | from_buf;
  wire brk_go   = tx_on & baud_ok & in_idle & brk_arm_q;
  wire seq_clr  = wr_ok & seen_q;
  wire [8:0] load_word = uart_pkg::frame_word({ctrl_q.tx_ninth_bit, from_buf ? buf_q : I_DATA}, // RULE11
                                              ctrl_q.nine_bit_select, ctrl_q.parity_enable,
                                              ctrl_q.parity_type_field); // RULE10 RULE24 RULE8
  wire [3:0] step    = uart_pkg::acc_step((load | brk_go) ? `ACC_ZERO : acc_q,
                                          ctrl_q.baud_fraction_field); // RULE22
  wire       bit_new = load | brk_go | (tick & ~in_idle & ~stop_end);
  wire [1:0] stops_n = ctrl_q.two_stop_select ? `STOPS_TWO : `STOPS_ONE; // RULE9
  wire       brk_due = hold_q > ({1'b0, ctrl_q.baud_divider} + `HOLD_ONE);
  wire       level_d = (state_d == uart_pkg::TX_DATA) ? shift_d[0] :
                       ((state_d == uart_pkg::TX_START) | (state_d == uart_pkg::TX_BREAK)) ? `START_LEVEL :
                       `IDLE_LEVEL; // RULE1 RULE4

  // transmit sequencer
  always_comb begin
    state_d = state_q;
    left_d  = left_q;
    stops_d = stops_q;
    shift_d = shift_q;
    brk_d   = brk_q;
    unique case (state_q)
      uart_pkg::TX_IDLE: begin
      end
      uart_pkg::TX_START: begin
        if (tick) begin
          state_d = brk_q ? uart_pkg::TX_BREAK : uart_pkg::TX_DATA;
          left_d  = brk_q ? `BREAK_BITS : uart_pkg::payload_bits(ctrl_q.nine_bit_select);
        end
      end
      uart_pkg::TX_DATA: begin
        if (tick) begin
          shift_d = shift_q >> 1;
          left_d  = left_q - `BITS_ONE;
          if (left_q == `BITS_ONE) begin
            state_d = uart_pkg::TX_STOP;
            stops_d = stops_n;
          end
        end
      end
      uart_pkg::TX_BREAK: begin
        if (tick) begin
          left_d = left_q - `BITS_ONE;
          if (left_q == `BITS_ONE) begin
            if (ctrl_q.break_request) begin // RULE21
              left_d = `BREAK_BITS;
            end else begin
              state_d = uart_pkg::TX_STOP;
              stops_d = stops_n;
            end
          end
        end
      end
      uart_pkg::TX_STOP: begin
        if (tick) begin
          stops_d = stops_q - `STOPS_ONE;
          if (stop_end) begin
            state_d = uart_pkg::TX_IDLE;
          end
        end
      end
    endcase
    if (load) begin
      state_d = uart_pkg::TX_START;
      shift_d = load_word;
      brk_d   = 1'b0;
    end
    if (brk_go) begin // RULE19
      state_d = uart_pkg::TX_START;
      brk_d   = 1'b1;
    end
    if (!tx_on) begin // RULE14 RULE7
      state_d = uart_pkg::TX_IDLE;
    end
  end

  // transmit and control registers
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_q     <= '0; // RULE2
      state_q    <= uart_pkg::TX_IDLE;
      cnt_q      <= `DIV_ZERO;
      acc_q      <= `ACC_ZERO;
      left_q     <= '0;
      stops_q    <= '0;
      shift_q    <= '0;
      brk_q      <= 1'b0;
      out_q      <= `IDLE_LEVEL;
      oe_q       <= 1'b0;
      seen_q     <= 1'b0;
      hold_q     <= `HOLD_ZERO;
      brk_arm_q  <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      state_q   <= state_d;
      left_q    <= left_d;
      stops_q   <= stops_d;
      shift_q   <= shift_d;
      brk_q     <= brk_d;
      out_q     <= level_d;
      oe_q      <= ctrl_d.port_enable & ctrl_d.transmit_enable; // RULE4 RULE5
      cnt_q     <= bit_new ? uart_pkg::bit_count(ctrl_q.baud_divider, step[`CARRY_BIT]) :
                   (tick ? cnt_q : cnt_q - `DIV_ONE); // RULE3
      acc_q     <= bit_new ? step[2:0] : acc_q;
      seen_q    <= I_STATUS_RD | (seen_q & ~I_DATA_WE & ~I_DATA_RD);
      hold_q    <= (ctrl_q.break_request & O_TX_IDLE & in_idle) ?
                   (brk_due ? hold_q : hold_q + `HOLD_ONE) : `HOLD_ZERO; // RULE19
      brk_arm_q <= tx_on & ctrl_q.break_request & ~brk_go & (brk_arm_q | brk_due);
    end
  end

  // transmit buffer and flags, hardware set wins over clear
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      buf_q      <= '0;
      buf_full_q <= 1'b0;
      O_TX_EMPTY <= 1'b1;
      O_TX_IDLE  <= 1'b1;
      O_IRQ      <= 1'b0;
    end else begin
      if (wr_ok & ~direct) begin
        buf_q <= I_DATA;
      end
      buf_full_q <= ctrl_q.port_enable & ((wr_ok & ~direct) | (buf_full_q & ~from_buf)); // RULE5
      O_TX_EMPTY <= ~ctrl_q.port_enable | from_buf | (O_TX_EMPTY & ~(wr_ok & ~direct)); // RULE15 RULE17
      O_TX_IDLE  <= ~ctrl_q.port_enable | stop_end | (O_TX_IDLE & ~seq_clr); // RULE18
      O_IRQ      <= ctrl_q.tx_interrupt_enable & O_TX_EMPTY; // RULE16 RULE20
    end
  end

  uart_rx_core u_rx (
    .i_clk       (I_CLK_SYS),
    .i_rstn      (I_RSTN),
    .i_active    (ctrl_q.port_enable & ctrl_q.receive_enable),
    .i_line      (LINK.serial_in),
    .i_ctrl      (ctrl_q),
    .o_done      (rx_done),
    .o_word      (rx_word),
    .o_frame_err (rx_ferr),
    .o_par_err   (rx_perr),
    .o_noise     (rx_noise),
    .o_busy      (rx_busy)
  );

  // receive holding register and flags
  wire rx_clr   = I_DATA_RD & seen_q;
  wire rx_full  = O_RX_AVAIL & ~rx_clr;
  wire rx_store = rx_done & ~rx_full;
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_RX_AVAIL <= 1'b0;
      O_RX_IDLE  <= 1'b1;
      O_OVERRUN  <= 1'b0;
      O_FRAMING  <= 1'b0;
      O_PARITY   <= 1'b0;
      O_NOISE    <= 1'b0;
      O_RX_DATA  <= '0;
    end else begin
      O_RX_IDLE  <= ~ctrl_q.port_enable | ~rx_busy; // RULE6
      O_RX_AVAIL <= ctrl_q.port_enable & (rx_done | rx_full);
      O_OVERRUN  <= ctrl_q.port_enable & ((rx_done & rx_full) | (O_OVERRUN & ~rx_clr));
      O_FRAMING  <= ctrl_q.port_enable & (rx_store ? rx_ferr : (O_FRAMING & ~rx_clr));
      O_PARITY   <= ctrl_q.port_enable & (rx_store ? rx_perr : (O_PARITY & ~rx_clr));
      O_NOISE    <= ctrl_q.port_enable & (rx_store ? rx_noise : (O_NOISE & ~rx_clr));
      if (rx_store) begin
        O_RX_DATA <= rx_word;
      end
    end
  end

  // outputs and line drive
  assign O_CTRL             = ctrl_q;
  assign O_RX_COUNT         = {2'h0, O_RX_AVAIL};
  assign LINK.serial_out    = out_q;
  assign LINK.serial_out_oe = oe_q;
endmodule

//--- core/uart_far.sv
// remote transceiver at the far end of the serial line
`include "uart_cfg.svh"
module uart_far (
  // clock and reset
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RSTN,
  // format and baud settings
  input  wire uart_pkg::ctrl_type I_FMT,
  // character to send
  input  wire logic               I_SEND,
  input  wire logic [8:0]         I_WORD,
  output logic                    O_READY,
  // character received
  output logic                    O_RX_VALID,
  output logic [8:0]              O_RX_WORD,
  output logic                    O_RX_FRAMING,
  output logic                    O_RX_PARITY,
  output logic                    O_RX_NOISE,
  // serial line
  uart_link_if.far                LINK
);
  logic [11:0] shift_q;
  logic [15:0] cnt_q;
  logic [2:0]  acc_q;
  logic [3:0]  left_q;
  logic        busy_q, out_q;

  // frame build: start, payload LSB first, stop bits
  wire [8:0]  fw    = uart_pkg::frame_word(I_WORD, I_FMT.nine_bit_select, I_FMT.parity_enable,
                                           I_FMT.parity_type_field); // RULE1
  wire [11:0] frm   = I_FMT.nine_bit_select ? {2'h3, fw, `START_LEVEL} : {3'h7, fw[7:0], `START_LEVEL};
  wire [3:0]  total = `BITS_ONE + uart_pkg::payload_bits(I_FMT.nine_bit_select) +
                      {2'h0, I_FMT.two_stop_select ? `STOPS_TWO : `STOPS_ONE};
  wire        go    = I_SEND & ~busy_q;
  wire        tick  = cnt_q == `DIV_ZERO;
  wire [3:0]  step  = uart_pkg::acc_step(go ? `ACC_ZERO : acc_q, I_FMT.baud_fraction_field);
  wire        more  = busy_q & tick & (left_q != `BITS_ONE);
  wire        done  = busy_q & tick & (left_q == `BITS_ONE);

  // sender
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      shift_q <= '1;
      cnt_q   <= `DIV_ZERO;
      acc_q   <= `ACC_ZERO;
      left_q  <= '0;
      busy_q  <= 1'b0;
      out_q   <= `IDLE_LEVEL;
      O_READY <= 1'b1;
    end else begin
      if (go) begin
        shift_q <= frm;
        left_q  <= total;
      end else if (more) begin
        shift_q <= (shift_q >> 1) | `FRAME_FILL;
        left_q  <= left_q - `BITS_ONE;
      end
      if (go | more) begin
        cnt_q <= uart_pkg::bit_count(I_FMT.baud_divider, step[`CARRY_BIT]);
        acc_q <= step[2:0];
      end else if (!tick) begin
        cnt_q <= cnt_q - `DIV_ONE;
      end
      busy_q  <= go | (busy_q & ~done);
      O_READY <= ~go & (~busy_q | done);
      out_q   <= go ? `START_LEVEL : (more ? shift_q[1] : (done ? `IDLE_LEVEL : out_q));
    end
  end

  assign LINK.serial_in = out_q;

  uart_rx_core u_rx (
    .i_clk       (I_CLK_SYS),
    .i_rstn      (I_RSTN),
    .i_active    (1'b1),
    .i_line      (LINK.line_tx),
    .i_ctrl      (I_FMT),
    .o_done      (O_RX_VALID),
    .o_word      (O_RX_WORD),
    .o_frame_err (O_RX_FRAMING),
    .o_par_err   (O_RX_PARITY),
    .o_noise     (O_RX_NOISE),
    .o_busy      ()
  );
endmodule

//--- sim/uart_checker.sv
// line-level assertions on the serial link between port and remote end
module uart_checker (
  // clock and reset
  input  wire logic I_CLK_SYS,
  input  wire logic I_RSTN,
  // link signals
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  input  wire logic serial_in,
  input  wire logic line_tx
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_MIN = 15;  // divider 16, one cycle less
  localparam int FAR_LOW = 170; // ten bits at the longest bit time
  logic [15:0] run_q;
  logic [15:0] frun_q;
  logic        last_q;
  logic        flast_q;
  logic        oe_q;
  wire         chg  = line_tx != last_q;
  wire         fchg = serial_in != flast_q;

  // level run length in each direction
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      run_q   <= 16'hffff;
      frun_q  <= 16'hffff;
      last_q  <= 1'b1;
      flast_q <= 1'b1;
      oe_q    <= 1'b0;
    end else begin
      run_q   <= chg ? 16'h0000 : run_q + {15'h0000, run_q != 16'hffff};
      frun_q  <= fchg ? 16'h0000 : frun_q + {15'h0000, frun_q != 16'hffff};
      last_q  <= line_tx;
      flast_q <= serial_in;
      oe_q    <= serial_out_oe;
    end
  end

  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);

  a_reset_out_idle: assert property ($rose(I_RSTN) |-> serial_out && !serial_out_oe)
    else $error("device line not idle after reset");
  a_reset_far_idle: assert property ($rose(I_RSTN) |-> serial_in)
    else $error("far line not idle after reset");
  a_start_holds: assert property ($fell(line_tx) && serial_out_oe |=> !line_tx [*8])
    else $error("device start bit too short");
  a_far_start_holds: assert property ($fell(serial_in) |=> !serial_in [*8])
    else $error("far start bit too short");
  a_bit_spacing: assert property (chg && serial_out_oe && oe_q |-> run_q >= BIT_MIN)
    else $error("device bit shorter than divider");
  a_far_bit_spacing: assert property (fchg |-> frun_q >= BIT_MIN)
    else $error("far bit shorter than divider");
  a_far_low_bound: assert property (!serial_in && !fchg |-> frun_q < FAR_LOW)
    else $error("far low run longer than a frame");
  a_enable_high: assert property ($rose(serial_out_oe) |-> serial_out)
    else $error("pin enabled while not idle high");

  // main traffic seen on the line
  c_dev_frame: cover property ($fell(line_tx) && serial_out_oe);
  c_far_frame: cover property ($fell(serial_in));
  c_pin_release: cover property ($fell(serial_out_oe));
endmodule

//--- sim/uart_port_bench.sv
// self-checking bench: port and remote end on one link
module uart_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk   = 1'b0;
  logic               rstn  = 1'b0;
  logic [4:0]         stb   = 5'h00; // ctrl we, status rd, data we, data rd, send
  logic [7:0]         d_in  = 8'h00;
  logic [8:0]         f_wd  = 9'h000;
  uart_pkg::ctrl_type ctrl  = '0;
  uart_pkg::ctrl_type base  = '0;
  uart_pkg::ctrl_type ctrl_rb;
  logic               tx_empty, tx_idle, irq, rx_avail, rx_idle, f_ready, f_valid, f_fe;
  logic [8:0]         rx_data, f_rx;
  logic [9:0]         got_q[$];
  int                 error_cnt  = 0;
  int                 num_checks = 0;

  uart_link_if link ();
  uart_port uart_port_inst (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_CTRL_WE(stb[0]), .I_CTRL(ctrl),
    .I_STATUS_RD(stb[1]), .I_DATA_WE(stb[2]), .I_DATA(d_in), .I_DATA_RD(stb[3]), .O_CTRL(ctrl_rb),
    .O_TX_EMPTY(tx_empty), .O_TX_IDLE(tx_idle), .O_IRQ(irq), .O_RX_AVAIL(rx_avail), .O_RX_IDLE(rx_idle),
    .O_OVERRUN(), .O_FRAMING(), .O_PARITY(), .O_NOISE(), .O_RX_COUNT(), .O_RX_DATA(rx_data), .LINK(link.dev));
  uart_far uart_far_inst (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_FMT(ctrl), .I_SEND(stb[4]), .I_WORD(f_wd),
    .O_READY(f_ready), .O_RX_VALID(f_valid), .O_RX_WORD(f_rx), .O_RX_FRAMING(f_fe), .O_RX_PARITY(),
    .O_RX_NOISE(), .LINK(link.far));
  uart_checker uart_checker_inst (.I_CLK_SYS(clk), .I_RSTN(rstn), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .serial_in(link.serial_in), .line_tx(link.line_tx));

  // clock and far-end capture
  always #10 clk = ~clk;
  always @(posedge clk) if (f_valid) got_q.push_back({f_fe, f_rx});

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(input int k);
    stb[k] <= 1'b1;
    @(posedge clk);
    stb[k] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic setcfg(input uart_pkg::ctrl_type c);
    ctrl <= c;
    pulse(0);
  endtask
  // status access then data write
  task automatic wr(input logic [7:0] d);
    d_in <= d;
    pulse(1);
    pulse(2);
  endtask
  task automatic get(input string what, input logic [9:0] w);
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 999) begin
      @(posedge clk);
      n++;
    end
    chk(what, w, got_q.size() > 0 ? got_q.pop_front() : 10'bx);
  endtask
  // one frame: cycles from the write to the idle flag, then the far word
  task automatic run(input logic [7:0] d, input int cyc, input logic [9:0] w);
    int n;
    setcfg(base);
    wr(d);
    n = 1;
    while (!tx_idle && n < 999) begin
      @(posedge clk);
      n++;
    end
    chk("frame cycles", 10'(cyc), 10'(n));
    get("far word", w);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial begin
    int n;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("reset state", 10'h007, {ctrl_rb.nine_bit_select, ctrl_rb.parity_enable, ctrl_rb.two_stop_select,
      tx_empty, tx_idle, rx_idle});
    base.port_enable = 1'b1;
    base.transmit_enable = 1'b1;
    base.receive_enable = 1'b1;
    base.baud_divider = 16'h0010;
    run(8'h35, 161, 10'h035);
    base.baud_fraction_field = 3'h3;
    run(8'h35, 164, 10'h035);
    base.baud_fraction_field = 3'h0;
    base.two_stop_select = 1'b1;
    run(8'h35, 177, 10'h035);
    base.nine_bit_select = 1'b1;
    base.tx_ninth_bit = 1'b1;
    run(8'ha5, 193, 10'h1a5);
    base.nine_bit_select = 1'b0;
    base.two_stop_select = 1'b0;
    base.parity_enable = 1'b1;
    for (int t = 0; t < 4; t++) begin
      base.parity_type_field = 2'(t);
      run(8'h35, 161, {2'b00, 1'(t == 1 || t == 2), 7'h35});
    end
    base.parity_enable = 1'b0;
    base.tx_interrupt_enable = 1'b1;
    setcfg(base);
    wr(8'h11);
    chk("empty after direct write", 10'h001, 10'(tx_empty));
    wr(8'h22);
    @(posedge clk);
    chk("empty and irq while held", 10'h000, {tx_empty, irq});
    wr(8'h33);
    get("first word", 10'h011);
    get("held word", 10'h022);
    repeat (400) @(posedge clk);
    chk("ignored write", 10'h000, 10'(got_q.size()));
    chk("empty and irq idle", 10'h003, {tx_empty, irq});
    base.transmit_enable = 1'b0;
    setcfg(base);
    wr(8'h44);
    repeat (300) @(posedge clk);
    chk("no send while disabled", 10'h000, 10'(got_q.size()));
    base.transmit_enable = 1'b1;
    setcfg(base);
    get("late enable word", 10'h044);
    wr(8'h55);
    repeat (40) @(posedge clk);
    base.transmit_enable = 1'b0;
    setcfg(base);
    chk("pin after abort", 10'h001, {link.serial_out_oe, link.line_tx});
    repeat (300) @(posedge clk);
    got_q.delete();
    base.transmit_enable = 1'b1;
    setcfg(base);
    wr(8'h66);
    wr(8'h77);
    repeat (40) @(posedge clk);
    base.port_enable = 1'b0;
    setcfg(base);
    @(posedge clk);
    chk("disable state", 10'h01d, {ctrl_rb.transmit_enable, ctrl_rb.receive_enable, ctrl_rb.break_request,
      tx_empty, tx_idle, rx_idle, rx_avail, link.line_tx});
    chk("kept divider", 10'h010, ctrl_rb.baud_divider[9:0]);
    repeat (300) @(posedge clk);
    got_q.delete();
    base.port_enable = 1'b1;
    setcfg(base);
    wr(8'h5a);
    get("word after re-enable", 10'h05a);
    repeat (300) @(posedge clk);
    chk("buffer emptied", 10'h000, 10'(got_q.size()));
    f_wd <= 9'h0c3;
    pulse(4);
    n = 0;
    while (!f_ready && n < 999) begin
      @(posedge clk);
      n++;
    end
    chk("received word", 10'h2c3, {rx_avail, rx_data});
    base.break_request = 1'b1;
    setcfg(base);
    repeat (300) @(posedge clk);
    chk("empty during break", 10'h001, 10'(tx_empty));
    base.break_request = 1'b0;
    setcfg(base);
    repeat (600) @(posedge clk);
    get("break frame", 10'h200);
    chk("flags after break", 10'h003, {tx_empty, tx_idle});
    wrap_up();
  end
endmodule
